// *** hw/gtc_regs.svh ***
// Register offsets, field positions, reset values and counts of the timer.
// Included by bare name; definitions only.
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH

// ==========================================================================
// Register offsets (16-bit word registers on the plain register port)
`define GTC_OFS_COUNT        16'h0100
`define GTC_OFS_PERIOD       16'h0102
`define GTC_OFS_CONTROL      16'h0104
`define GTC_OFS_FLAG         16'h0106

// ==========================================================================
// Control register field positions
`define GTC_BIT_TIMER_ON     15
`define GTC_BIT_IDLE_STOP    13
`define GTC_BIT_GATE_EN      6
`define GTC_BIT_PS_HI        5
`define GTC_BIT_PS_LO        4
`define GTC_BIT_EXT_SYNC     2
`define GTC_BIT_CLK_SRC      1
`define GTC_CTRL_MASK        16'hA076

// Flag register field position
`define GTC_BIT_EVENT_FLAG   0

// ==========================================================================
// Reset values
`define GTC_RST_COUNT        16'h0000
`define GTC_RST_PERIOD       16'hFFFF
`define GTC_RST_CONTROL      16'h0000

// ==========================================================================
// Prescaler terminal counts (ratio minus one)
`define GTC_PS_TERM_1        8'h00
`define GTC_PS_TERM_8        8'h07
`define GTC_PS_TERM_64       8'h3F
`define GTC_PS_TERM_256      8'hFF

`endif

// *** hw/gtc_pkg.sv ***
// Types shared by the timer/counter modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package gtc_pkg;

  // ========================================================================
  // Prescale ratio codes
  typedef enum logic [1:0] {
    GTC_PS_DIV1   = 2'h0,
    GTC_PS_DIV8   = 2'h1,
    GTC_PS_DIV64  = 2'h2,
    GTC_PS_DIV256 = 2'h3
  } gtc_ps_t;

  // ========================================================================
  // Count source
  typedef enum logic [1:0] {
    GTC_SRC_INSTR = 2'h0,
    GTC_SRC_GATED = 2'h1,
    GTC_SRC_SYNC  = 2'h2,
    GTC_SRC_ASYNC = 2'h3
  } gtc_src_t;

endpackage : gtc_pkg

`default_nettype wire

// *** hw/gtc_ps_if.sv ***
// Carrier between the timer core and its prescaler.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none

interface gtc_ps_if;
  logic             src_tick;
  logic             run;
  logic             clear;
  gtc_pkg::gtc_ps_t sel;
  logic             out_tick;

  modport core (output src_tick, output run, output clear, output sel, input out_tick);
  modport ps   (input src_tick, input run, input clear, input sel, output out_tick);
endinterface : gtc_ps_if

`default_nettype wire

// *** hw/gtc_prescaler.sv ***
// Prescaler of the timer: divides source ticks by 1, 8, 64 or 256.
// Assumes source ticks are one-cycle pulses on the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_regs.svh"

module gtc_prescaler (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Link to the core
  gtc_ps_if.ps      ps
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] term;
  logic       at_term;
  logic       step;

  // ========================================================================
  // Ratio select
  assign term = (ps.sel == gtc_pkg::GTC_PS_DIV1)  ? `GTC_PS_TERM_1  :
                (ps.sel == gtc_pkg::GTC_PS_DIV8)  ? `GTC_PS_TERM_8  :
                (ps.sel == gtc_pkg::GTC_PS_DIV64) ? `GTC_PS_TERM_64 :
                                                    `GTC_PS_TERM_256;
  assign step        = ps.src_tick & ps.run;
  assign at_term     = (cnt_q >= term);
  assign ps.out_tick = step & at_term;
  // Clear is honoured only while running: a halted prescaler clock cannot reset it
  assign cnt_d = (ps.clear & ps.run) ? 8'h00 :
                 step ? (at_term ? 8'h00 : cnt_q + 8'h01) : cnt_q;

  // ========================================================================
  // Counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : gtc_prescaler

`default_nettype wire

// *** hw/gtc_timer.sv ***
// 16-bit general-purpose timer/counter with period wrap, gating and prescaler.
// Assumes a 50 MHz core clock, pins synchronous to it, and a plain register port.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_regs.svh"

module gtc_timer #(
  parameter int INSTR_DIV = 1
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Pins and core state
  input  wire logic        external_clock_gate_pin,
  input  wire logic        cpu_idle,
  // Status
  output logic             timer_event_flag,
  output logic      [15:0] count_value,
  output logic             timer_running
);

  // ========================================================================
  // Declarations
  logic [15:0] count_value_reg_q;
  logic [15:0] count_value_reg_d;
  logic [15:0] period_value_reg_q;
  logic [15:0] timer_control_reg_q;
  logic        flag_q;
  logic        flag_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [7:0]  div_cnt_q;
  logic        instr_tick;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic        pin_sync_dly_q;
  logic        pin_raw_dly_q;
  logic        gate_dly_q;
  logic        ext_rise_sync;
  logic        ext_rise_async;
  logic        gate_fall;

  // Control fields
  logic             timer_on_bit;
  logic             idle_stop_select;
  logic             gate_accumulate_enable;
  gtc_pkg::gtc_ps_t prescale_select;
  logic             clock_source_select;
  logic             external_sync_select;
  gtc_pkg::gtc_src_t src_mode;

  // Decode and strobes
  logic        sel_count;
  logic        sel_period;
  logic        sel_control;
  logic        sel_flag;
  logic        wr_count;
  logic        wr_period;
  logic        wr_control;
  logic        wr_flag;
  logic        flag_clear;
  logic        paused;
  logic        src_tick;
  logic        cnt_tick;
  logic        period_match;
  logic        match_event;
  logic        gate_event;

  gtc_ps_if    ps_link ();

  // ========================================================================
  // Register decode
  assign sel_count   = (reg_addr == `GTC_OFS_COUNT);
  assign sel_period  = (reg_addr == `GTC_OFS_PERIOD);
  assign sel_control = (reg_addr == `GTC_OFS_CONTROL);
  assign sel_flag    = (reg_addr == `GTC_OFS_FLAG);
  assign wr_count    = reg_wr & sel_count;
  assign wr_period   = reg_wr & sel_period;
  assign wr_control  = reg_wr & sel_control;
  assign wr_flag     = reg_wr & sel_flag;
  // Write-one-to-clear keeps a read-modify-write from losing a fresh event
  assign flag_clear  = wr_flag & reg_wdata[`GTC_BIT_EVENT_FLAG];

  // ========================================================================
  // Control fields
  assign timer_on_bit           = timer_control_reg_q[`GTC_BIT_TIMER_ON];
  assign idle_stop_select       = timer_control_reg_q[`GTC_BIT_IDLE_STOP];
  assign gate_accumulate_enable = timer_control_reg_q[`GTC_BIT_GATE_EN];
  assign prescale_select        =
    gtc_pkg::gtc_ps_t'(timer_control_reg_q[`GTC_BIT_PS_HI:`GTC_BIT_PS_LO]);
  assign clock_source_select    = timer_control_reg_q[`GTC_BIT_CLK_SRC];
  assign external_sync_select   = timer_control_reg_q[`GTC_BIT_EXT_SYNC];

  // Gating is only defined with the internal source; external source ignores it
  assign src_mode =
    clock_source_select ?
      (external_sync_select ? gtc_pkg::GTC_SRC_SYNC
                            : gtc_pkg::GTC_SRC_ASYNC) :
      (gate_accumulate_enable ? gtc_pkg::GTC_SRC_GATED
                              : gtc_pkg::GTC_SRC_INSTR);

  // ========================================================================
  // Instruction cycle enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt_q <= 8'h00;
    end else if (instr_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  assign instr_tick = (div_cnt_q >= 8'(INSTR_DIV - 1));

  // ========================================================================
  // External pin: synchroniser and edge detectors
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta_q     <= 1'b0;
      pin_sync_q     <= 1'b0;
      pin_sync_dly_q <= 1'b0;
      pin_raw_dly_q  <= 1'b0;
      gate_dly_q     <= 1'b0;
    end else begin
      pin_meta_q     <= external_clock_gate_pin;
      pin_sync_q     <= pin_meta_q;
      pin_sync_dly_q <= pin_sync_q;
      pin_raw_dly_q  <= external_clock_gate_pin;
      gate_dly_q     <= pin_sync_q;
    end
  end

  // Synchronised edge lags the pin by two cycles more than the bypass path
  assign ext_rise_sync  = pin_sync_q & ~pin_sync_dly_q;
  // Bypass path: the pin is taken as-is, no synchroniser stages
  assign ext_rise_async = external_clock_gate_pin & ~pin_raw_dly_q;
  assign gate_fall      = gate_dly_q & ~pin_sync_q;

  // ========================================================================
  // Count source select and idle stop
  always_comb begin
    case (src_mode)
      gtc_pkg::GTC_SRC_INSTR: src_tick = instr_tick;
      gtc_pkg::GTC_SRC_GATED: src_tick = instr_tick & pin_sync_q;
      gtc_pkg::GTC_SRC_SYNC:  src_tick = ext_rise_sync;
      gtc_pkg::GTC_SRC_ASYNC: src_tick = ext_rise_async;
      default:                src_tick = 1'b0;
    endcase
  end

  // Idle stop freezes every mode, asynchronous counter included
  assign paused = cpu_idle & idle_stop_select;

  // ========================================================================
  // Prescaler
  assign ps_link.src_tick = src_tick;
  assign ps_link.run      = timer_on_bit & ~paused;
  // Clearing events: count write and control write; reset clears inside
  assign ps_link.clear    = wr_count | wr_control;
  assign ps_link.sel      = prescale_select;
  assign cnt_tick         = ps_link.out_tick;

  gtc_prescaler u_prescaler (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ps       (ps_link.ps)
  );

  // ========================================================================
  // Count and period match
  assign period_match = (count_value_reg_q == period_value_reg_q);
  assign match_event  = cnt_tick & period_match;

  // A count write wins over a tick in the same cycle
  assign count_value_reg_d =
    wr_count ? reg_wdata :
    cnt_tick ? (period_match ? 16'h0000
                             : count_value_reg_q + 16'h0001) :
    count_value_reg_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_value_reg_q <= `GTC_RST_COUNT;
    end else begin
      count_value_reg_q <= count_value_reg_d;
    end
  end

  // ========================================================================
  // Period and control registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      period_value_reg_q  <= `GTC_RST_PERIOD;
      timer_control_reg_q <= `GTC_RST_CONTROL;
    end else begin
      if (wr_period) begin
        period_value_reg_q <= reg_wdata;
      end
      if (wr_control) begin
        timer_control_reg_q <= reg_wdata & `GTC_CTRL_MASK;
      end
    end
  end

  // ========================================================================
  // Event flag
  // Gate falling edge counts only while gated accumulation is live
  assign gate_event = gate_fall & timer_on_bit &
                      (src_mode == gtc_pkg::GTC_SRC_GATED);
  // Set beats clear so an event in the clearing cycle survives
  assign flag_d = (match_event | gate_event) ? 1'b1 :
                  flag_clear ? 1'b0 : flag_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ========================================================================
  // Read data, valid the cycle after the read strobe
  assign rdata_d =
    ~reg_rd     ? 16'h0000 :
    sel_count   ? count_value_reg_q :
    sel_period  ? period_value_reg_q :
    sel_control ? timer_control_reg_q :
    sel_flag    ? {15'h0000, flag_q} :
                  16'h0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata        = rdata_q;
  assign timer_event_flag = flag_q;
  assign count_value      = count_value_reg_q;
  assign timer_running    = timer_on_bit & ~paused;

endmodule : gtc_timer

`default_nettype wire

// *** testbench/gtc_pin_src.sv ***
// Model of the source on the external clock / gate pin.
// Assumes the bench sets half period, run and idle level between bursts.
`timescale 1ns/1ns
`default_nettype none

module gtc_pin_src (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Control from the bench
  input  wire logic        run,
  input  wire logic [3:0]  half,
  input  wire logic        level,
  // Pin and tally of rising edges
  output logic             pin,
  output logic      [15:0] n_rise
);
  // ==========================================================================
  // Toggle generator; outside a burst the pin rests at the given level
  logic [3:0] ph_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ph_q   <= 4'h0;
      pin    <= 1'b0;
      n_rise <= 16'h0000;
    end else if (!run) begin
      ph_q <= 4'h0;
      pin  <= level;
    end else if (ph_q >= half - 4'h1) begin
      ph_q   <= 4'h0;
      pin    <= !pin;
      n_rise <= n_rise + 16'(!pin);
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end
endmodule : gtc_pin_src

`default_nettype wire

// *** testbench/gtc_timer_monitor.sv ***
// Port-level checks of the timer, bound onto every gtc_timer.
// Assumes one clock; period and control are mirrored from register writes.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_regs.svh"

module gtc_timer_monitor #(
  parameter int INSTR_DIV = 1
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and status
  input wire logic        external_clock_gate_pin,
  input wire logic        cpu_idle,
  input wire logic        timer_event_flag,
  input wire logic [15:0] count_value,
  input wire logic        timer_running
);
  // ==========================================================================
  // Mirrors of period and control
  logic [15:0] prd_q;
  logic [15:0] ctl_q;
  wire logic wr_cnt = reg_wr && reg_addr == `GTC_OFS_COUNT;
  wire logic wr_ctl = reg_wr && reg_addr == `GTC_OFS_CONTROL;
  wire logic clr_flag = reg_wr && reg_addr == `GTC_OFS_FLAG && reg_wdata[0];
  wire logic gated = ctl_q[`GTC_BIT_GATE_EN] && !ctl_q[`GTC_BIT_CLK_SRC];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prd_q <= `GTC_RST_PERIOD;
      ctl_q <= `GTC_RST_CONTROL;
    end else begin
      if (reg_wr && reg_addr == `GTC_OFS_PERIOD) prd_q <= reg_wdata;
      if (wr_ctl) ctl_q <= reg_wdata & `GTC_CTRL_MASK;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence rd_cnt_s;
    reg_rd && reg_addr == `GTC_OFS_COUNT;
  endsequence
  sequence tick_s;
    !$past(wr_cnt) && $changed(count_value);
  endsequence

  cnt_load_a: assert property (wr_cnt |=> count_value == $past(reg_wdata))
    else $error("count write not loaded");
  ctl_keep_a: assert property (wr_ctl && !timer_running |=> $stable(count_value))
    else $error("control write moved the count");
  cnt_step_a: assert property (tick_s |-> count_value ==
    ($past(count_value) == $past(prd_q) ? 16'h0000 : $past(count_value) + 16'h0001))
    else $error("count step wrong");
  wrap_flag_a: assert property (tick_s ##0 $past(count_value) == $past(prd_q)
    |-> timer_event_flag) else $error("no flag on period match");
  flag_hold_a: assert property (timer_event_flag && !clr_flag |=> timer_event_flag)
    else $error("flag dropped by itself");
  frozen_a: assert property (!timer_running && !wr_cnt |=> $stable(count_value))
    else $error("count moved while stopped");
  idle_stop_a: assert property (cpu_idle && ctl_q[`GTC_BIT_IDLE_STOP]
    |-> !timer_running) else $error("running during idle stop");
  run_on_a: assert property (ctl_q[`GTC_BIT_TIMER_ON] &&
    !(cpu_idle && ctl_q[`GTC_BIT_IDLE_STOP]) |-> timer_running) else $error("not running");
  gate_hold_a: assert property ((!external_clock_gate_pin && gated)[*3] ##0 !wr_cnt
    |=> $stable(count_value)) else $error("count moved with gate low");
  rd_cnt_a: assert property (rd_cnt_s |=> reg_rdata == $past(count_value))
    else $error("count read wrong");
  rd_quiet_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without read");
endmodule : gtc_timer_monitor

bind gtc_timer gtc_timer_monitor #(.INSTR_DIV(INSTR_DIV)) i_gtc_timer_monitor (
  .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .external_clock_gate_pin, .cpu_idle, .timer_event_flag, .count_value, .timer_running
);

`default_nettype wire

// *** testbench/gtc_timer_bench.sv ***
// Self-checking bench of the timer: registers, prescaler, idle, pin modes, gate.
// Assumes gtc_regs.svh on the include path and the pin model beside it.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_regs.svh"

module gtc_timer_bench;
  // ==========================================================================
  // Signals
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [15:0] reg_addr  = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        cpu_idle  = 1'b0;
  logic        run       = 1'b0;
  logic        level     = 1'b0;
  logic [3:0]  half      = 4'h1;
  logic [15:0] reg_rdata, count_value, n_rise, d, base;
  logic        pin, timer_event_flag, timer_running;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n, p, g;
  int          rt[4] = '{1, 8, 64, 256};
  logic [15:0] mode[3] = '{16'h8006, 16'h8002, 16'hA002};

  always #10 core_clk = ~core_clk;

  gtc_timer #(.INSTR_DIV(1)) i_gtc_timer (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_clock_gate_pin(pin), .cpu_idle, .timer_event_flag, .count_value,
    .timer_running
  );
  gtc_pin_src i_gtc_pin_src (.core_clk, .sys_rst, .run, .half, .level, .pin, .n_rise);

  // ==========================================================================
  // Bus cycles and comparison
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk

  // Fixed waits only: every latency here is set by the hand-over timing
  task automatic cnt_after(input int k, input logic [15:0] exp);
    repeat (k) @(posedge core_clk);
    #1 chk(count_value, exp);
  endtask : cnt_after

  // Count after k source ticks at ratio r, wrapping to zero after per
  function automatic logic [15:0] exp_cnt(input int k, input int r, input int per);
    return 16'((k / r) % (per + 1));
  endfunction : exp_cnt

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(44));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(`GTC_OFS_COUNT, `GTC_RST_COUNT);
    rd_chk(`GTC_OFS_PERIOD, `GTC_RST_PERIOD);
    wr(16'h0108, 16'h8000);
    rd_chk(16'h0108, 16'h0000);
    wr(`GTC_OFS_CONTROL, 16'h5F89);
    rd_chk(`GTC_OFS_CONTROL, `GTC_RST_CONTROL);
    // Gate bit left out: gating with the pin as count source is not allowed
    wr(`GTC_OFS_CONTROL, 16'hFFBF);
    rd_chk(`GTC_OFS_CONTROL, `GTC_CTRL_MASK & 16'hFFBF);
    d = 16'($urandom);
    wr(`GTC_OFS_PERIOD, d);
    rd_chk(`GTC_OFS_PERIOD, d);
    $display("Test registers done");
    for (int c = 0; c < 4; c++) begin
      p = 2 + $urandom % 8;
      n = $urandom % (rt[c] * (p + 1) * 2);
      wr(`GTC_OFS_CONTROL, 16'h0000);
      wr(`GTC_OFS_FLAG, 16'h0001);
      #1 chk({15'h0, timer_event_flag}, 16'h0000);
      wr(`GTC_OFS_PERIOD, 16'(p));
      wr(`GTC_OFS_COUNT, 16'h0000);
      wr(`GTC_OFS_CONTROL, 16'h8000 | 16'(c << 4));
      cnt_after(n, exp_cnt(n, rt[c], p));
      chk({15'h0, timer_event_flag}, {15'h0, n / rt[c] > p});
    end
    $display("Test prescaler done");
    wr(`GTC_OFS_CONTROL, 16'h0000);
    wr(`GTC_OFS_PERIOD, `GTC_RST_PERIOD);
    wr(`GTC_OFS_CONTROL, 16'hA010);
    repeat (5) @(posedge core_clk);
    cpu_idle <= 1'b1;
    d = 16'($urandom);
    wr(`GTC_OFS_COUNT, d);
    cpu_idle <= 1'b0;
    cnt_after(2, d);
    cnt_after(1, d + 16'h0001);
    repeat (3) @(posedge core_clk);
    d = 16'($urandom % 16'hFF00);
    wr(`GTC_OFS_COUNT, d);
    cnt_after(7, d);
    cnt_after(1, d + 16'h0001);
    wr(`GTC_OFS_CONTROL, 16'h8010);
    cnt_after(7, d + 16'h0001);
    cnt_after(1, d + 16'h0002);
    $display("Test idle and clearing done");
    for (int m = 0; m < 3; m++) begin
      wr(`GTC_OFS_CONTROL, 16'h0000);
      wr(`GTC_OFS_COUNT, 16'h0000);
      wr(`GTC_OFS_CONTROL, mode[m]);
      half <= 4'(1 + $urandom % 6);
      base = n_rise;
      run <= 1'b1;
      cpu_idle <= 1'b1;
      repeat (60 + $urandom % 60) @(posedge core_clk);
      run <= 1'b0;
      // Idle is held past the last edge so a late rise cannot slip through
      repeat (3) @(posedge core_clk);
      cpu_idle <= 1'b0;
      cnt_after(3, mode[m][13] ? 16'h0000 : n_rise - base);
    end
    $display("Test pin modes done");
    wr(`GTC_OFS_COUNT, 16'h0000);
    wr(`GTC_OFS_FLAG, 16'h0001);
    wr(`GTC_OFS_CONTROL, 16'h8040);
    g = 3 + $urandom % 40;
    level <= 1'b1;
    repeat (g) @(posedge core_clk);
    level <= 1'b0;
    cnt_after(6, 16'(g));
    chk({15'h0, timer_event_flag}, 16'h0001);
    rd_chk(`GTC_OFS_FLAG, 16'h0001);
    $display("Test gate done");
    print_verdict();
  end
endmodule : gtc_timer_bench

`default_nettype wire
